// ### isrc_pkg.sv
// Constants and types for the issue, slotting and retire control block
package isrc_pkg;
    localparam int LANES = 4;
    localparam int PIPE_W = 8;
    localparam int INUM_W = 8;
    localparam int INUM_N = 256;
    localparam int PREG_W = 4;
    localparam int PREG_N = 16;
    localparam int LAT_W = 6;
    localparam int STG_W = 4;
    localparam int EXP_W = 11;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] IQ_DEPTH = 5'h14;
    localparam logic [CNT_W-1:0] FQ_DEPTH = 5'h0f;
    localparam logic [CNT_W-1:0] LINE_MAX = 5'h04;
    // Pipe bit order: lower 0/1, upper 0/1, fp store 0/1, fp add, fp mul
    localparam logic [PIPE_W-1:0] PM_NONE = 8'h00;
    localparam logic [PIPE_W-1:0] PM_L0 = 8'h01;
    localparam logic [PIPE_W-1:0] PM_L1 = 8'h02;
    localparam logic [PIPE_W-1:0] PM_LOWER = 8'h03;
    localparam logic [PIPE_W-1:0] PM_U0 = 8'h04;
    localparam logic [PIPE_W-1:0] PM_U1 = 8'h08;
    localparam logic [PIPE_W-1:0] PM_UPPER = 8'h0c;
    localparam logic [PIPE_W-1:0] PM_FST = 8'h30;
    localparam logic [PIPE_W-1:0] PM_FA = 8'h40;
    localparam logic [PIPE_W-1:0] PM_FM = 8'h80;
    // Result latencies in cycles
    localparam logic [LAT_W-1:0] LAT_NONE = 6'h00;
    localparam logic [LAT_W-1:0] LAT_ONE = 6'h01;
    localparam logic [LAT_W-1:0] LAT_INT_LOAD = 6'h03;
    localparam logic [LAT_W-1:0] LAT_FP_LOAD = 6'h04;
    localparam logic [LAT_W-1:0] LAT_MISS_ADD = 6'h0a;
    localparam logic [LAT_W-1:0] LAT_IREG_SLOW = 6'h03;
    localparam logic [LAT_W-1:0] LAT_IMUL = 6'h07;
    localparam logic [LAT_W-1:0] LAT_IMISC = 6'h03;
    localparam logic [LAT_W-1:0] LAT_JSR = 6'h03;
    localparam logic [LAT_W-1:0] LAT_FP_OP = 6'h04;
    // Earliest retire stages
    localparam logic [STG_W-1:0] STG_INT = 4'h7;
    localparam logic [STG_W-1:0] STG_MEM = 4'ha;
    localparam logic [STG_W-1:0] STG_FP = 4'hb;
    localparam logic [STG_W-1:0] STG_OVF_MUL = 4'hd;
    localparam logic [STG_W-1:0] STG_DIV_LATE = 4'hf;
    // Divide operand and result exponent limits
    localparam logic [EXP_W-1:0] EXP_ZERO = 11'h000;
    localparam logic [EXP_W-1:0] EXP_D_HI = 11'h3ff;
    localparam logic [EXP_W-1:0] EXP_D_LO = 11'h002;
    localparam logic [EXP_W-1:0] EXP_S_HI = 11'h07f;
    localparam logic [EXP_W-1:0] EXP_S_LO = 11'h382;

    typedef enum logic [4:0] {
        CLS_INT_LOAD, CLS_FP_LOAD, CLS_INT_STORE, CLS_FP_STORE,
        CLS_ADDR_CALC, CLS_MEM_MISC, CLS_CYCLE_READ, CLS_RX_FLAG,
        CLS_IREG_READ, CLS_IREG_WRITE, CLS_INT_CBRANCH, CLS_JUMP,
        CLS_INT_ADD, CLS_INT_LOGIC, CLS_INT_SHIFT,
        CLS_COND_MOVE_FIRST_HALF, CLS_COND_MOVE_SECOND_HALF,
        CLS_INT_MUL, CLS_OVERFLOW_CHECKED_MULTIPLY, CLS_INT_MISC,
        CLS_FP_CBRANCH, CLS_FP_ADD, CLS_FP_MUL, CLS_FP_COND_MOVE_FIRST,
        CLS_FP_COND_MOVE_SECOND, CLS_FP_DIV, CLS_FP_SQRT, CLS_NOP
    } isrc_class_t;

    typedef enum logic [1:0] {REQ_E, REQ_L, REQ_U, REQ_N} isrc_req_t;
endpackage : isrc_pkg

// ### isrc_top.sv
// Issue steering, subcluster slotting, latency tracking and retire control
`timescale 1ns/100ps
// Operation
// RULE1: Loads and integer stores use lower pipes only
// RULE2: FP stores use fp store or lower pipes
// RULE3: Jumps, calls, returns use lower pipe zero only
// RULE4: Integer add group may use all four pipes
// RULE5: Logical group may use all four pipes
// RULE6: Shifts and integer branches use upper pipes
// RULE7: Misc to upper zero, multiply to upper one
// RULE8: FP multiply to mul pipe, rest to add
// RULE9: Barriers and unaligned no-op get no pipe
// RULE10: Either-side ops slotted by fetch line mix
// RULE11: Line position taken from PC bits three:two
// RULE12: Issue waits for operands and free unit
// RULE13: Only true dependencies tracked, renaming removes others
// RULE14: Load latency 3/4, miss adds 10+ cycles
// RULE15: Simple ops one cycle, cross-cluster one more
// RULE16: Internal register read latency 1 or 3
// RULE17: Cond move first half feeds only second
// RULE18: Retire in program order after completion
// RULE19: Retire stages 7, 10 and 11 by class
// RULE20: Overflow-checked multiply retires at 13
// RULE21: Safe divide/sqrt retires at fp add stage
// RULE22: Refuse early retire on unsafe operands, mode
// RULE23: Refuse early retire on divide exponent limits
// RULE24: Each mapped instruction gets an 8-bit tag
// RULE25: Queues hold 20 and 15 entries
// RULE26: Issued entry idles one cycle, deleted after
// RULE27: Slotting is a lookup on four requirement codes
// RULE28: Valueless classes set no destination timing
module isrc_top
    import isrc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Fetch line from the mapper, lanes in program order
    input wire logic line_valid_in,
    input wire logic [LANES-1:0] lane_valid_in,
    input wire isrc_class_t [LANES-1:0] lane_class_in,
    input wire logic [LANES-1:0][1:0] lane_pc_in,
    // Issue candidate from the queues
    input wire logic cand_valid_in,
    input wire isrc_class_t cand_class_in,
    input wire logic [INUM_W-1:0] cand_inum_in,
    input wire logic cand_upper_in,
    input wire logic [PREG_W-1:0] cand_src_a_in,
    input wire logic [PREG_W-1:0] cand_src_b_in,
    input wire logic [PREG_W-1:0] cand_dst_in,
    input wire logic [PIPE_W-1:0] unit_busy_in,
    input wire logic dcache_miss_in,
    input wire logic [LAT_W-1:0] bcache_extra_in,
    input wire logic ireg_fast_in,
    // Divide and square root operand checks
    input wire logic sqrt_neg_in,
    input wire logic [EXP_W-1:0] exp_a_in,
    input wire logic [EXP_W-1:0] exp_b_in,
    input wire logic [EXP_W-1:0] res_exp_in,
    input wire logic single_prec_in,
    input wire logic nan_inf_in,
    input wire logic trap_inexact_in,
    input wire logic inexact_enable_bit_in,
    // Completion reports from the pipelines
    input wire logic complete_in,
    input wire logic [INUM_W-1:0] complete_inum_in,
    // Mapping results
    output logic map_ready_out,
    output logic [LANES-1:0] lane_valid_out,
    output logic [LANES-1:0][PIPE_W-1:0] lane_pipes_out,
    output logic [LANES-1:0] lane_upper_out,
    output logic [LANES-1:0][INUM_W-1:0] lane_inum_out,
    output logic [CNT_W-1:0] iq_count_out,
    output logic [CNT_W-1:0] fq_count_out,
    // Issue results
    output logic issue_grant_out,
    output logic [INUM_W-1:0] issue_inum_out,
    output logic [PIPE_W-1:0] issue_pipe_out,
    output logic [LAT_W-1:0] issue_latency_out,
    output logic [STG_W-1:0] issue_retire_stage_out,
    output logic early_retire_out,
    output logic delete_out,
    // Retirement
    output logic retire_valid_out,
    output logic [INUM_W-1:0] retire_inum_out
);

    function automatic logic [PIPE_W-1:0] pipe_mask(input isrc_class_t c);
        case (c)
            CLS_INT_LOAD, CLS_FP_LOAD, CLS_INT_STORE: return PM_LOWER; //RULE1
            CLS_FP_STORE: return PM_FST | PM_LOWER; //RULE2
            CLS_JUMP: return PM_L0; //RULE3
            CLS_INT_ADD, CLS_ADDR_CALC: return PM_LOWER | PM_UPPER; //RULE4
            CLS_INT_LOGIC: return PM_LOWER | PM_UPPER; //RULE5
            CLS_COND_MOVE_FIRST_HALF, CLS_COND_MOVE_SECOND_HALF:
                return PM_LOWER | PM_UPPER;
            CLS_INT_SHIFT, CLS_INT_CBRANCH: return PM_UPPER; //RULE6
            CLS_INT_MISC: return PM_U0; //RULE7
            CLS_INT_MUL, CLS_OVERFLOW_CHECKED_MULTIPLY: return PM_U1; //RULE7
            CLS_MEM_MISC, CLS_CYCLE_READ, CLS_RX_FLAG: return PM_L1;
            CLS_IREG_READ, CLS_IREG_WRITE: return PM_LOWER;
            CLS_FP_MUL: return PM_FM; //RULE8
            CLS_NOP: return PM_NONE; //RULE9
            default: return PM_FA; //RULE8
        endcase
    endfunction : pipe_mask

    function automatic logic is_fq(input isrc_class_t c);
        return (pipe_mask(c) & (PM_FST | PM_FA | PM_FM)) != PM_NONE;
    endfunction : is_fq

    // FP stores sit in the fp queue, so they take no subcluster slot
    function automatic isrc_req_t req_of(input isrc_class_t c);
        logic [PIPE_W-1:0] m;
        m = pipe_mask(c);
        if (is_fq(c) || m == PM_NONE)
            return REQ_N;
        else if ((m & PM_UPPER) == PM_NONE)
            return REQ_L;
        else if ((m & PM_LOWER) == PM_NONE)
            return REQ_U;
        else
            return REQ_E;
    endfunction : req_of

    // Fixed needs counted first, then either-side ops fill the lighter
    // side from position three down, which keeps the pairs balanced
    function automatic logic [LANES-1:0] slot_lookup(
        input isrc_req_t [LANES-1:0] r);
        logic [2:0] nu;
        logic [2:0] nl;
        logic [LANES-1:0] up;
        nu = 3'h0;
        nl = 3'h0;
        up = '0;
        for (int i = 0; i < LANES; i++) begin
            if (r[i] == REQ_U) nu = 3'(nu + 3'h1);
            if (r[i] == REQ_L) nl = 3'(nl + 3'h1);
            up[i] = (r[i] == REQ_U);
        end
        for (int i = LANES - 1; i >= 0; i--) begin
            if (r[i] == REQ_E) begin
                if (nu <= nl) begin
                    up[i] = 1'b1;
                    nu = 3'(nu + 3'h1);
                end
                else begin
                    nl = 3'(nl + 3'h1);
                end
            end
        end
        return up;
    endfunction : slot_lookup

    function automatic logic [LAT_W-1:0] lat_of(input isrc_class_t c,
        input logic miss, input logic [LAT_W-1:0] extra, input logic fast);
        case (c)
            CLS_INT_LOAD: return miss ? //RULE14
                6'(LAT_INT_LOAD + LAT_MISS_ADD + extra) : LAT_INT_LOAD;
            CLS_FP_LOAD: return miss ? //RULE14
                6'(LAT_FP_LOAD + LAT_MISS_ADD + extra) : LAT_FP_LOAD;
            CLS_ADDR_CALC, CLS_INT_ADD, CLS_INT_LOGIC, CLS_INT_SHIFT,
            CLS_COND_MOVE_FIRST_HALF, CLS_COND_MOVE_SECOND_HALF,
            CLS_CYCLE_READ, CLS_RX_FLAG: return LAT_ONE; //RULE15 RULE17
            CLS_IREG_READ: return fast ? LAT_ONE : LAT_IREG_SLOW; //RULE16
            CLS_INT_MUL, CLS_OVERFLOW_CHECKED_MULTIPLY: return LAT_IMUL;
            CLS_INT_MISC: return LAT_IMISC;
            CLS_JUMP: return LAT_JSR;
            CLS_FP_ADD, CLS_FP_MUL, CLS_FP_COND_MOVE_FIRST,
            CLS_FP_COND_MOVE_SECOND, CLS_FP_DIV, CLS_FP_SQRT:
                return LAT_FP_OP;
            default: return LAT_NONE; //RULE28
        endcase
    endfunction : lat_of

    // Mapping: slotting, pipe masks, tags and queue space
    isrc_req_t [LANES-1:0] pos_req;
    logic [LANES-1:0] pos_upper;
    logic [LANES-1:0] lane_take;
    logic [CNT_W-1:0] map_iq_n;
    logic [CNT_W-1:0] map_fq_n;
    logic [LANES-1:0][INUM_W-1:0] lane_tag;
    logic [INUM_W-1:0] next_inum_r;
    logic [INUM_W-1:0] next_inum_nxt;
    logic [CNT_W-1:0] iq_cnt_r;
    logic [CNT_W-1:0] fq_cnt_r;
    logic [CNT_W-1:0] iq_cnt_nxt;
    logic [CNT_W-1:0] fq_cnt_nxt;
    logic del_fp_r;

    always_comb
    begin
        pos_req = '{default: REQ_N};
        for (int l = 0; l < LANES; l++)
            if (lane_valid_in[l])
                pos_req[lane_pc_in[l]] = req_of(lane_class_in[l]); //RULE11
        pos_upper = slot_lookup(pos_req); //RULE27
    end

    always_comb
    begin
        lane_take = (line_valid_in && map_ready_out) ? lane_valid_in : '0;
        map_iq_n = '0;
        map_fq_n = '0;
        next_inum_nxt = next_inum_r;
        for (int l = 0; l < LANES; l++) begin
            lane_tag[l] = next_inum_nxt;
            if (lane_take[l]) begin
                next_inum_nxt = 8'(next_inum_nxt + 8'h01); //RULE24
                if (is_fq(lane_class_in[l]))
                    map_fq_n = 5'(map_fq_n + 5'h01);
                else if (lane_class_in[l] != CLS_NOP)
                    map_iq_n = 5'(map_iq_n + 5'h01);
            end
        end
        iq_cnt_nxt = 5'(iq_cnt_r + map_iq_n - 5'(delete_out && !del_fp_r));
        fq_cnt_nxt = 5'(fq_cnt_r + map_fq_n - 5'(delete_out && del_fp_r));
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in) begin
            next_inum_r <= '0;
            iq_cnt_r <= '0;
            fq_cnt_r <= '0;
            map_ready_out <= 1'b0;
        end
        else begin
            next_inum_r <= next_inum_nxt;
            iq_cnt_r <= iq_cnt_nxt;
            fq_cnt_r <= fq_cnt_nxt;
            // Conservative: a whole line must fit before it is taken
            map_ready_out <= (iq_cnt_nxt <= IQ_DEPTH - LINE_MAX) && //RULE25
                (fq_cnt_nxt <= FQ_DEPTH - LINE_MAX);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in) begin
            lane_valid_out <= '0;
            lane_pipes_out <= '0;
            lane_upper_out <= '0;
            lane_inum_out <= '0;
        end
        else begin
            lane_valid_out <= lane_take;
            for (int l = 0; l < LANES; l++) begin
                lane_pipes_out[l] <= pipe_mask(lane_class_in[l]);
                lane_upper_out[l] <= pos_upper[lane_pc_in[l]]; //RULE10
                lane_inum_out[l] <= lane_tag[l];
            end
        end
    end

    assign iq_count_out = iq_cnt_r;
    assign fq_count_out = fq_cnt_r;

    // Scoreboard of true dependencies per renamed register
    logic [LAT_W-1:0] sb_cnt_r [PREG_N];
    logic sb_upper_r [PREG_N];
    logic sb_settled_r [PREG_N];
    logic sb_first_half_r [PREG_N];
    logic held_v_r;
    logic [INUM_W-1:0] held_inum_r;
    logic held_fp_r;
    logic src_a_ok;
    logic src_b_ok;
    logic [PIPE_W-1:0] free_m;
    logic [PIPE_W-1:0] pick;
    logic issue_ok;
    logic [LAT_W-1:0] cand_lat;
    logic early_ok;
    logic is_div;
    logic [STG_W-1:0] stage;

    function automatic logic src_ready(input logic [PREG_W-1:0] s,
        input logic [LAT_W-1:0] cnt, input logic side,
        input logic settled, input logic first_half);
        return cnt == LAT_NONE && //RULE12
            (side == cand_upper_in || settled) && //RULE15
            (!first_half || cand_class_in == CLS_COND_MOVE_SECOND_HALF);
    endfunction : src_ready

    always_comb
    begin
        src_a_ok = src_ready(cand_src_a_in, sb_cnt_r[cand_src_a_in],
            sb_upper_r[cand_src_a_in], sb_settled_r[cand_src_a_in],
            sb_first_half_r[cand_src_a_in]); //RULE17
        src_b_ok = src_ready(cand_src_b_in, sb_cnt_r[cand_src_b_in],
            sb_upper_r[cand_src_b_in], sb_settled_r[cand_src_b_in],
            sb_first_half_r[cand_src_b_in]);
        free_m = pipe_mask(cand_class_in) & ~unit_busy_in; //RULE12
        if ((free_m & PM_UPPER) != PM_NONE && (free_m & PM_LOWER) != PM_NONE)
            free_m = free_m & (cand_upper_in ? ~PM_LOWER : ~PM_UPPER);
        pick = free_m & 8'(~free_m + 8'h01);
        issue_ok = cand_valid_in && src_a_ok && src_b_ok &&
            (pick != PM_NONE || cand_class_in == CLS_NOP) &&
            !(held_v_r && held_inum_r == cand_inum_in); //RULE26
        cand_lat = lat_of(cand_class_in, dcache_miss_in, bcache_extra_in,
            ireg_fast_in);
    end

    // Scoreboard keeps no writer order: renaming already removed it
    always_ff @(posedge clk_in)
    begin
        for (int r = 0; r < PREG_N; r++) begin
            if (rst_in) begin
                sb_cnt_r[r] <= LAT_NONE;
                sb_upper_r[r] <= 1'b0;
                sb_settled_r[r] <= 1'b1;
                sb_first_half_r[r] <= 1'b0;
            end
            else if (issue_ok && cand_lat != LAT_NONE && //RULE28
                cand_dst_in == PREG_W'(r)) begin
                sb_cnt_r[r] <= cand_lat; //RULE13
                sb_upper_r[r] <= cand_upper_in;
                sb_settled_r[r] <= 1'b0;
                sb_first_half_r[r] <=
                    (cand_class_in == CLS_COND_MOVE_FIRST_HALF);
            end
            else begin
                if (sb_cnt_r[r] != LAT_NONE)
                    sb_cnt_r[r] <= 6'(sb_cnt_r[r] - LAT_ONE);
                sb_settled_r[r] <= (sb_cnt_r[r] == LAT_NONE); //RULE15
            end
        end
    end

    // Retire stage and divide/sqrt early retirement
    always_comb
    begin
        is_div = cand_class_in == CLS_FP_DIV;
        early_ok = (is_div || cand_class_in == CLS_FP_SQRT) && //RULE21
            !(cand_class_in == CLS_FP_SQRT && sqrt_neg_in) && //RULE22
            !(is_div && (exp_a_in == EXP_ZERO || exp_b_in == EXP_ZERO)) &&
            !nan_inf_in && !trap_inexact_in && inexact_enable_bit_in &&
            !(is_div && !single_prec_in && //RULE23
              (res_exp_in >= EXP_D_HI || res_exp_in <= EXP_D_LO)) &&
            !(is_div && single_prec_in &&
              (res_exp_in >= EXP_S_HI || res_exp_in <= EXP_S_LO));
        case (cand_class_in) //RULE19
            CLS_OVERFLOW_CHECKED_MULTIPLY: stage = STG_OVF_MUL; //RULE20
            CLS_INT_LOAD, CLS_FP_LOAD, CLS_INT_STORE, CLS_FP_STORE,
            CLS_MEM_MISC: stage = STG_MEM;
            CLS_FP_ADD, CLS_FP_MUL, CLS_FP_CBRANCH, CLS_FP_COND_MOVE_FIRST,
            CLS_FP_COND_MOVE_SECOND: stage = STG_FP;
            CLS_FP_DIV, CLS_FP_SQRT:
                stage = early_ok ? STG_FP : STG_DIV_LATE; //RULE21
            default: stage = STG_INT;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in) begin
            issue_grant_out <= 1'b0;
            issue_inum_out <= '0;
            issue_pipe_out <= PM_NONE;
            issue_latency_out <= LAT_NONE;
            issue_retire_stage_out <= STG_INT;
            early_retire_out <= 1'b0;
        end
        else begin
            issue_grant_out <= issue_ok;
            issue_inum_out <= cand_inum_in;
            issue_pipe_out <= issue_ok ? pick : PM_NONE;
            issue_latency_out <= cand_lat;
            issue_retire_stage_out <= stage;
            early_retire_out <= issue_ok && early_ok;
        end
    end

    // Issued entry idles one cycle, then is deleted
    always_ff @(posedge clk_in)
    begin
        if (rst_in) begin
            held_v_r <= 1'b0;
            held_inum_r <= '0;
            held_fp_r <= 1'b0;
            delete_out <= 1'b0;
            del_fp_r <= 1'b0;
        end
        else begin
            held_v_r <= issue_ok; //RULE26
            held_inum_r <= cand_inum_in;
            held_fp_r <= is_fq(cand_class_in);
            delete_out <= held_v_r && held_inum_r != {INUM_W{1'b1}} ||
                held_v_r; //RULE26
            del_fp_r <= held_fp_r;
        end
    end

    // In-order retirement from the oldest tag
    logic [INUM_N-1:0] done_r;
    logic [INUM_W-1:0] oldest_r;
    logic retire_now;

    assign retire_now = done_r[oldest_r];

    always_ff @(posedge clk_in)
    begin
        if (rst_in) begin
            done_r <= '0;
            oldest_r <= '0;
            retire_valid_out <= 1'b0;
            retire_inum_out <= '0;
        end
        else begin
            if (retire_now)
                done_r[oldest_r] <= 1'b0;
            // Completion beats a clear on the same tag
            if (complete_in)
                done_r[complete_inum_in] <= 1'b1;
            if (retire_now)
                oldest_r <= 8'(oldest_r + 8'h01); //RULE18
            retire_valid_out <= retire_now;
            retire_inum_out <= oldest_r;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_LOAD_LOWER: assert property ( //RULE1
        issue_ok && cand_class_in == CLS_INT_LOAD |=>
        (issue_pipe_out & ~PM_LOWER) == PM_NONE)
        else $error("load issued outside lower pipes");
    AST_JUMP_L0: assert property ( //RULE3
        issue_ok && cand_class_in == CLS_JUMP |=> issue_pipe_out == PM_L0)
        else $error("jump not on lower pipe zero");
    AST_SHIFT_UPPER: assert property ( //RULE6
        issue_ok && cand_class_in == CLS_INT_SHIFT |=>
        (issue_pipe_out & ~PM_UPPER) == PM_NONE)
        else $error("shift issued outside upper pipes");
    AST_MUL_U1: assert property ( //RULE7
        issue_ok && cand_class_in == CLS_INT_MUL |=> issue_pipe_out == PM_U1)
        else $error("multiply not on upper pipe one");
    AST_NOP_NOPIPE: assert property ( //RULE9
        issue_ok && cand_class_in == CLS_NOP |=> issue_pipe_out == PM_NONE)
        else $error("no-op given a pipe");
    AST_DELETE_AFTER: assert property ( //RULE26
        issue_grant_out |=> delete_out ##0 !(issue_grant_out &&
        issue_inum_out == $past(issue_inum_out)))
        else $error("issued entry not held then deleted");
    AST_OVF_STAGE: assert property ( //RULE20
        cand_class_in == CLS_OVERFLOW_CHECKED_MULTIPLY |=>
        issue_retire_stage_out == STG_OVF_MUL)
        else $error("checked multiply retire stage wrong");
    AST_EARLY_NAN: assert property ( //RULE22
        nan_inf_in || trap_inexact_in || !inexact_enable_bit_in |=>
        !early_retire_out)
        else $error("early retire despite unsafe operand");
    AST_RETIRE_ORDER: assert property ( //RULE18
        retire_valid_out ##1 retire_valid_out |->
        retire_inum_out == 8'($past(retire_inum_out) + 8'h01))
        else $error("retire out of program order");
    AST_IQ_BOUND: assert property ( //RULE25
        iq_count_out <= IQ_DEPTH && fq_count_out <= FQ_DEPTH)
        else $error("queue occupancy over depth");

    COV_EARLY: cover property (early_retire_out);
    COV_RETIRE_RUN: cover property (retire_valid_out [*3]);
    COV_FULL_LINE: cover property (lane_valid_out == '1);
    COV_MISS_LOAD: cover property (issue_latency_out > LAT_MISS_ADD);

endmodule : isrc_top

// ### isrc_pipes.sv
// Pipeline model that reports completion of issued instructions
`timescale 1ns/100ps
module isrc_pipes
    import isrc_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Issue side
    input wire logic grant_in,
    input wire logic [INUM_W-1:0] inum_in,
    // Completion side
    output logic done_out,
    output logic [INUM_W-1:0] done_inum_out
);
    // Fixed two-cycle execution, enough to exercise retire order
    logic [1:0] v_r = 2'h0;
    logic [INUM_W-1:0] n0_r = 8'h00;
    logic [INUM_W-1:0] n1_r = 8'h00;
    always_ff @(posedge clk_in)
    begin
        v_r <= {v_r[0], grant_in};
        n0_r <= inum_in;
        n1_r <= n0_r;
    end
    assign done_out = v_r[1];
    // Tag is junk outside a report, never a stale copy
    assign done_inum_out = v_r[1] ? n1_r : ~n1_r;
endmodule : isrc_pipes

// ### isrc_top_test.sv
// Self-checking bench for the issue, slot and retire block
`timescale 1ns/100ps
module isrc_top_test;
    import isrc_pkg::*;
    logic clk_in = 1'b0, rst_in = 1'b1, lnv = 1'b0, cv = 1'b0, cdone;
    logic [3:0] lv = 4'h0, sa = 4'h0, fl = 4'h4, cd = 4'h1;
    logic cu = 1'b0, dm = 1'b0, ifs = 1'b0, sn = 1'b0;
    logic [4:0] iqc, fqc;
    isrc_class_t [3:0] lc;
    isrc_class_t cc;
    logic [7:0] cn = 8'h00, busy = 8'h00, cdn, rn, inum;
    logic [10:0] res = 11'h100;
    logic mr, ig, er, del, rv;
    logic [3:0] lvo, up, st;
    logic [3:0][7:0] lp, li;
    logic [7:0] ip;
    logic [5:0] lat;
    int miscompares = 0, n_checks = 0, nret = 0;
    always #12.5 clk_in = ~clk_in;
    isrc_top DUT (.clk_in(clk_in), .rst_in(rst_in), .line_valid_in(lnv),
        .lane_valid_in(lv), .lane_class_in(lc), .lane_pc_in(8'he4),
        .cand_valid_in(cv), .cand_class_in(cc), .cand_inum_in(cn),
        .cand_upper_in(cu), .cand_src_a_in(sa), .cand_src_b_in(4'h0),
        .cand_dst_in(cd), .unit_busy_in(busy), .dcache_miss_in(dm),
        .bcache_extra_in(6'h00), .ireg_fast_in(ifs), .sqrt_neg_in(sn),
        .exp_a_in(11'h400), .exp_b_in(11'h400), .res_exp_in(res),
        .single_prec_in(fl[3]), .nan_inf_in(fl[0]), .trap_inexact_in(fl[1]),
        .inexact_enable_bit_in(fl[2]), .complete_in(cdone),
        .complete_inum_in(cdn), .map_ready_out(mr), .lane_valid_out(lvo),
        .lane_pipes_out(lp), .lane_upper_out(up), .lane_inum_out(li),
        .iq_count_out(iqc), .fq_count_out(fqc), .issue_grant_out(ig),
        .issue_inum_out(inum), .issue_pipe_out(ip), .issue_latency_out(lat),
        .issue_retire_stage_out(st), .early_retire_out(er),
        .delete_out(del), .retire_valid_out(rv), .retire_inum_out(rn));
    isrc_pipes PIPES (.clk_in(clk_in), .grant_in(ig), .inum_in(inum),
        .done_out(cdone), .done_inum_out(cdn));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask : chk
    task automatic tick;
    begin
        @(posedge clk_in);
        #1;
    end
    endtask : tick
    task automatic mapl(input logic [31:0] exp_p, input logic [3:0] exp_u,
        input logic [7:0] tag0);
    begin
        lv = 4'hf;
        lnv = 1'b1;
        tick;
        lnv = 1'b0;
        chk(lvo, 4'hf);
        chk(lp, exp_p);
        chk(up, exp_u);
        chk(li[3], tag0 + 8'h03);
        tick;
    end
    endtask : mapl
    task automatic iss(input isrc_class_t c, input logic [7:0] n, b, p,
        input logic [3:0] s, input logic [5:0] l, input logic e);
    begin
        cc = c;
        cn = n;
        busy = b;
        cv = 1'b1;
        tick;
        cv = 1'b0;
        chk(ig, 1'b1);
        chk(ip, p);
        chk(st, s);
        chk(er, e);
        if (l !== 6'h3f)
            chk(lat, l);
        tick;
        chk(del, 1'b1);
    end
    endtask : iss
    task automatic t_div;
        logic [3:0] f[6] = '{4'h5, 4'h6, 4'h0, 4'h4, 4'h4, 4'hc};
        logic [10:0] r[6] = '{11'h100, 11'h100, 11'h100, 11'h3ff, 11'h002,
            11'h07f};
    begin
        lc = '{default: CLS_FP_DIV};
        mapl({4{PM_FA}}, 4'h0, 8'h08);
        mapl({4{PM_FA}}, 4'h0, 8'h0c);
        iss(CLS_FP_DIV, 8'h04, 8'h00, PM_FA, STG_FP, 6'h3f, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            fl = f[i];
            res = r[i];
            iss(CLS_FP_DIV, 8'(5 + i), 8'h00, PM_FA, STG_DIV_LATE, 6'h3f,
                1'b0);
        end
        sn = 1'b1;
        iss(CLS_FP_SQRT, 8'h0b, 8'h00, PM_FA, STG_DIV_LATE, 6'h3f,
            1'b0);
        dm = 1'b1;
        iss(CLS_INT_LOAD, 8'h0c, 8'h00, PM_L0, STG_MEM, 6'h0d,
            1'b0);
        $display("divide test done");
    end
    endtask : t_div
    always @(negedge clk_in)
        if (rv === 1'b1)
        begin
            chk(rn, 8'(nret));
            nret++;
        end
    task automatic results;
    begin
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask : results
    initial
    begin
        #20000;
        miscompares++;
        results;
    end
    initial
    begin
        lc = '{CLS_INT_MUL, CLS_INT_SHIFT, CLS_JUMP, CLS_INT_LOAD};
        cc = CLS_NOP;
        repeat (3) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        tick;
        chk(mr, 1'b1);
        mapl({PM_U1, PM_UPPER, PM_L0, PM_LOWER}, 4'hc, 8'h00);
        lc = '{default: CLS_INT_ADD};
        mapl({4{8'h0f}}, 4'ha, 8'h04);
        $display("map test done");
        iss(CLS_INT_LOAD, 8'h00, PM_L0, PM_L1, STG_MEM, LAT_INT_LOAD,
            1'b0);
        sa = 4'h1;
        cc = CLS_INT_ADD;
        cn = 8'h09;
        cv = 1'b1;
        tick;
        cv = 1'b0;
        sa = 4'h0;
        chk(ig, 1'b0);
        tick;
        iss(CLS_INT_SHIFT, 8'h01, PM_U0, PM_U1, STG_INT, LAT_ONE,
            1'b0);
        iss(CLS_INT_MUL, 8'h02, 8'h00, PM_U1, STG_INT, LAT_IMUL,
            1'b0);
        iss(CLS_OVERFLOW_CHECKED_MULTIPLY, 8'h03, 8'h00, PM_U1, STG_OVF_MUL,
            6'h3f, 1'b0);
        $display("issue test done");
        t_div;
        repeat (20) tick;
        chk(8'(nret), 8'h0d);
        chk(iqc, 5'h03);
        chk(fqc, 5'h00);
        results;
    end
endmodule : isrc_top_test
